// File: common/echo_grp_pkg.sv
`default_nettype none
package echo_grp_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_GROUPS = 3;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int CTRL_W = 8;
  localparam int BYPASS_FRAMES = 2;
  localparam logic [1:0] INIT_FRAMES = 2'h2;
  // ----------------------------------------
  // Register indices (byte address = 4 x index)
  // ----------------------------------------
  localparam logic [11:0] IDX_GRP1 = 12'h401;
  localparam logic [11:0] IDX_GRP2 = 12'h402;
  localparam logic [11:0] IDX_GRP3 = 12'h403;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'h410;
  localparam logic [11:0] IDX_IRQ_MASK = 12'h411;
  localparam logic [11:0] IDX_GRP_STATE = 12'h412;
  // ----------------------------------------
  // Main control fields
  // ----------------------------------------
  localparam int BIT_PWR = 0;
  localparam int BIT_LAW = 1;
  localparam int BIT_FMT = 2;
  localparam int BIT_MASK_A = 3;
  localparam int BIT_MASK_B = 4;
  localparam logic [7:0] CTRL_USED = 8'h1F;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // ----------------------------------------
  // Status, mask and group state layouts
  // ----------------------------------------
  localparam int ST_PER_GRP = 3;
  localparam int ST_TONE_A = 0;
  localparam int ST_TONE_B = 1;
  localparam int ST_INIT_DONE = 2;
  localparam int STATUS_W = 9;
  localparam logic [8:0] MASK_RESET = 9'h000;
  localparam int GS_PER_GRP = 2;
  localparam int GS_ON = 0;
  localparam int GS_BUSY = 1;
  // ----------------------------------------
  // Bus responses, group states and register selects
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [1:0] {
    GS_DOWN = 2'b00,
    GS_INIT = 2'b01,
    GS_UP = 2'b10
  } grp_state_t;
  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_GRP1 = 3'b001,
    SEL_GRP2 = 3'b010,
    SEL_GRP3 = 3'b011,
    SEL_STATUS = 3'b100,
    SEL_MASK = 3'b101,
    SEL_STATE = 3'b110
  } reg_sel_t;
endpackage
`default_nettype wire

// File: rtl/echo_group_main_control.sv
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module echo_group_main_control #(
  parameter int SAMPLE_W = 8
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // AXI4-Lite write
  input wire logic [15:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read
  input wire logic [15:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // PCM pins
  input wire logic FRAME_SYNC,
  input wire logic [echo_grp_pkg::NUM_GROUPS-1:0][SAMPLE_W-1:0] RIN,
  input wire logic [echo_grp_pkg::NUM_GROUPS-1:0][SAMPLE_W-1:0] SIN,
  output logic [echo_grp_pkg::NUM_GROUPS-1:0][SAMPLE_W-1:0] ROUT,
  output logic [echo_grp_pkg::NUM_GROUPS-1:0][SAMPLE_W-1:0] SOUT,
  // Canceller side
  output logic [echo_grp_pkg::NUM_GROUPS-1:0][SAMPLE_W-1:0] CANC_RIN,
  output logic [echo_grp_pkg::NUM_GROUPS-1:0][SAMPLE_W-1:0] CANC_SIN,
  input wire logic [echo_grp_pkg::NUM_GROUPS-1:0][SAMPLE_W-1:0] CANC_ROUT,
  input wire logic [echo_grp_pkg::NUM_GROUPS-1:0][SAMPLE_W-1:0] CANC_SOUT,
  output logic [echo_grp_pkg::NUM_GROUPS-1:0] CANC_ENABLE,
  output logic [echo_grp_pkg::NUM_GROUPS-1:0] CANC_ALAW,
  output logic [echo_grp_pkg::NUM_GROUPS-1:0] CANC_INIT,
  input wire logic [echo_grp_pkg::NUM_GROUPS-1:0] TONE_A_EVT,
  input wire logic [echo_grp_pkg::NUM_GROUPS-1:0] TONE_B_EVT,
  // Interrupt
  output logic IRQ
);
  localparam int NG = echo_grp_pkg::NUM_GROUPS;
  localparam int NB = echo_grp_pkg::BYPASS_FRAMES;

  if (SAMPLE_W < 1 || SAMPLE_W > 16) begin : g_bad_width
    $error("SAMPLE_W must be 1 to 16");
  end

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_held;
    logic w_held;
    logic [15:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [2:0] fsync;
    logic [NG-1:0][SAMPLE_W-1:0] rin_s1;
    logic [NG-1:0][SAMPLE_W-1:0] rin_s2;
    logic [NG-1:0][SAMPLE_W-1:0] sin_s1;
    logic [NG-1:0][SAMPLE_W-1:0] sin_s2;
    logic [NG-1:0][7:0] ctrl;
    echo_grp_pkg::grp_state_t [NG-1:0] gst;
    logic [NG-1:0][1:0] init_cnt;
    logic [NG-1:0][NB-1:0][SAMPLE_W-1:0] rbp;
    logic [NG-1:0][NB-1:0][SAMPLE_W-1:0] sbp;
    logic [NG-1:0][SAMPLE_W-1:0] rout;
    logic [NG-1:0][SAMPLE_W-1:0] sout;
    logic [NG-1:0][SAMPLE_W-1:0] canc_rin;
    logic [NG-1:0][SAMPLE_W-1:0] canc_sin;
    logic [NG-1:0] enable;
    logic [NG-1:0] alaw;
    logic [NG-1:0] init;
    logic [8:0] status;
    logic [8:0] mask;
    logic irq;
  } state_t;

  state_t st;
  state_t nx;
  logic frame_tick;
  logic wr_go;
  logic [8:0] set_bits;
  logic [8:0] clr_bits;
  logic [8:0] lanes;
  logic [8:0] tone_mask;
  logic [8:0] gated;
  echo_grp_pkg::reg_sel_t wsel;
  echo_grp_pkg::reg_sel_t rsel;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic echo_grp_pkg::reg_sel_t decode(input logic [15:0] a);
    decode = echo_grp_pkg::SEL_NONE;
    if (a[1:0] == 2'h0) begin
      case (a[15:2])
        {2'h0, echo_grp_pkg::IDX_GRP1}: decode = echo_grp_pkg::SEL_GRP1;
        {2'h0, echo_grp_pkg::IDX_GRP2}: decode = echo_grp_pkg::SEL_GRP2;
        {2'h0, echo_grp_pkg::IDX_GRP3}: decode = echo_grp_pkg::SEL_GRP3;
        {2'h0, echo_grp_pkg::IDX_IRQ_STATUS}: decode = echo_grp_pkg::SEL_STATUS;
        {2'h0, echo_grp_pkg::IDX_IRQ_MASK}: decode = echo_grp_pkg::SEL_MASK;
        {2'h0, echo_grp_pkg::IDX_GRP_STATE}: decode = echo_grp_pkg::SEL_STATE;
        default: decode = echo_grp_pkg::SEL_NONE;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nx = st;
    frame_tick = st.fsync[1] & ~st.fsync[2];
    nx.fsync = {st.fsync[1:0], FRAME_SYNC};
    nx.rin_s1 = RIN;
    nx.rin_s2 = st.rin_s1;
    nx.sin_s1 = SIN;
    nx.sin_s2 = st.sin_s1;
    set_bits = '0;
    clr_bits = '0;
    tone_mask = '0;
    lanes = {st.wstrb[1], {8{st.wstrb[0]}}};
    wsel = decode(st.waddr);
    rsel = decode(ARADDR);
    // Write channel
    if (AWVALID && st.awready) begin
      nx.aw_held = 1'b1;
      nx.waddr = AWADDR;
    end
    if (WVALID && st.wready) begin
      nx.w_held = 1'b1;
      nx.wdata = WDATA;
      nx.wstrb = WSTRB;
    end
    if (st.bvalid && BREADY) begin
      nx.bvalid = 1'b0;
    end
    wr_go = st.aw_held && st.w_held && !st.bvalid;
    if (wr_go) begin
      nx.aw_held = 1'b0;
      nx.w_held = 1'b0;
      nx.bvalid = 1'b1;
      nx.bresp = echo_grp_pkg::RESP_OKAY;
      case (wsel)
        echo_grp_pkg::SEL_GRP1, echo_grp_pkg::SEL_GRP2, echo_grp_pkg::SEL_GRP3: begin
          if (st.wstrb[0]) begin
            nx.ctrl[int'(wsel) - 1] = st.wdata[7:0] & echo_grp_pkg::CTRL_USED;
          end
        end
        echo_grp_pkg::SEL_STATUS: begin
          clr_bits = st.wdata[8:0] & lanes;
        end
        echo_grp_pkg::SEL_MASK: begin
          nx.mask = (st.mask & ~lanes) | (st.wdata[8:0] & lanes);
        end
        echo_grp_pkg::SEL_STATE: begin
        end
        default: begin
          nx.bresp = echo_grp_pkg::RESP_DECERR;
        end
      endcase
    end
    // Per group power, init and PCM path
    for (int g = 0; g < NG; g++) begin
      case (st.gst[g])
        echo_grp_pkg::GS_DOWN: begin
          if (st.ctrl[g][echo_grp_pkg::BIT_PWR]) begin
            nx.gst[g] = echo_grp_pkg::GS_INIT;
            nx.init_cnt[g] = 2'h0;
          end
        end
        echo_grp_pkg::GS_INIT: begin
          if (!st.ctrl[g][echo_grp_pkg::BIT_PWR]) begin
            nx.gst[g] = echo_grp_pkg::GS_DOWN;
          end else if (frame_tick) begin
            if (st.init_cnt[g] == echo_grp_pkg::INIT_FRAMES - 2'h1) begin
              nx.gst[g] = echo_grp_pkg::GS_UP;
              set_bits[g*echo_grp_pkg::ST_PER_GRP + echo_grp_pkg::ST_INIT_DONE] = 1'b1;
            end else begin
              nx.init_cnt[g] = st.init_cnt[g] + 2'h1;
            end
          end
        end
        echo_grp_pkg::GS_UP: begin
          if (!st.ctrl[g][echo_grp_pkg::BIT_PWR]) begin
            nx.gst[g] = echo_grp_pkg::GS_DOWN;
          end
        end
        default: begin
          nx.gst[g] = echo_grp_pkg::GS_DOWN;
        end
      endcase
      nx.enable[g] = nx.gst[g] != echo_grp_pkg::GS_DOWN;
      nx.init[g] = nx.gst[g] == echo_grp_pkg::GS_INIT;
      nx.alaw[g] = st.ctrl[g][echo_grp_pkg::BIT_LAW];
      if (frame_tick) begin
        nx.canc_rin[g] = st.rin_s2[g];
        nx.canc_sin[g] = st.sin_s2[g];
        nx.rbp[g][0] = st.rin_s2[g];
        nx.sbp[g][0] = st.sin_s2[g];
        for (int k = 1; k < NB; k++) begin
          nx.rbp[g][k] = st.rbp[g][k-1];
          nx.sbp[g][k] = st.sbp[g][k-1];
        end
        if (st.gst[g] == echo_grp_pkg::GS_DOWN) begin
          nx.rout[g] = st.rbp[g][NB-1];
          nx.sout[g] = st.sbp[g][NB-1];
        end else begin
          nx.rout[g] = CANC_ROUT[g];
          nx.sout[g] = CANC_SOUT[g];
        end
      end
      // Detection is recorded whatever the masks say
      set_bits[g*echo_grp_pkg::ST_PER_GRP + echo_grp_pkg::ST_TONE_A] = TONE_A_EVT[g];
      set_bits[g*echo_grp_pkg::ST_PER_GRP + echo_grp_pkg::ST_TONE_B] = TONE_B_EVT[g];
      tone_mask[g*echo_grp_pkg::ST_PER_GRP + echo_grp_pkg::ST_TONE_A] =
        st.ctrl[g][echo_grp_pkg::BIT_MASK_A];
      tone_mask[g*echo_grp_pkg::ST_PER_GRP + echo_grp_pkg::ST_TONE_B] =
        st.ctrl[g][echo_grp_pkg::BIT_MASK_B];
    end
    // Set wins over a same-cycle clear
    nx.status = (st.status & ~clr_bits) | set_bits;
    gated = st.status & st.mask & ~tone_mask;
    nx.irq = |gated;
    // Read channel
    if (st.rvalid && RREADY) begin
      nx.rvalid = 1'b0;
    end
    if (ARVALID && st.arready) begin
      nx.rvalid = 1'b1;
      nx.rdata = '0;
      nx.rresp = echo_grp_pkg::RESP_OKAY;
      case (rsel)
        echo_grp_pkg::SEL_GRP1, echo_grp_pkg::SEL_GRP2, echo_grp_pkg::SEL_GRP3: begin
          nx.rdata[7:0] = st.ctrl[int'(rsel) - 1];
        end
        echo_grp_pkg::SEL_STATUS: begin
          nx.rdata[8:0] = st.status;
        end
        echo_grp_pkg::SEL_MASK: begin
          nx.rdata[8:0] = st.mask;
        end
        echo_grp_pkg::SEL_STATE: begin
          for (int g = 0; g < NG; g++) begin
            nx.rdata[g*echo_grp_pkg::GS_PER_GRP + echo_grp_pkg::GS_ON] = st.enable[g];
            nx.rdata[g*echo_grp_pkg::GS_PER_GRP + echo_grp_pkg::GS_BUSY] = st.init[g];
          end
        end
        default: begin
          nx.rresp = echo_grp_pkg::RESP_DECERR;
        end
      endcase
    end
    nx.awready = !nx.aw_held && !nx.bvalid;
    nx.wready = !nx.w_held && !nx.bvalid;
    nx.arready = !nx.rvalid;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign AWREADY = st.awready;
  assign WREADY = st.wready;
  assign BVALID = st.bvalid;
  assign BRESP = st.bresp;
  assign ARREADY = st.arready;
  assign RVALID = st.rvalid;
  assign RDATA = st.rdata;
  assign RRESP = st.rresp;
  assign ROUT = st.rout;
  assign SOUT = st.sout;
  assign CANC_RIN = st.canc_rin;
  assign CANC_SIN = st.canc_sin;
  assign CANC_ENABLE = st.enable;
  assign CANC_ALAW = st.alaw;
  assign CANC_INIT = st.init;
  assign IRQ = st.irq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_mask_b_block: assert property (@(posedge CLK) disable iff (!RST_N)
    (st.status == 9'h002) && st.mask[1] && st.ctrl[0][echo_grp_pkg::BIT_MASK_B] |=> !IRQ)
    else $error("masked tone B raised interrupt");
  a_detect_kept: assert property (@(posedge CLK) disable iff (!RST_N)
    TONE_B_EVT[0] && st.ctrl[0][echo_grp_pkg::BIT_MASK_B] |=> st.status[1])
    else $error("masked tone B not recorded");
  a_law_follows: assert property (@(posedge CLK) disable iff (!RST_N)
    $stable(st.ctrl[0][echo_grp_pkg::BIT_LAW]) |-> CANC_ALAW[0] == st.ctrl[0][echo_grp_pkg::BIT_LAW])
    else $error("law select does not follow control");
  a_power_runs: assert property (@(posedge CLK) disable iff (!RST_N)
    st.gst[0] == echo_grp_pkg::GS_UP && st.ctrl[0][0] |=> CANC_ENABLE[0] && !CANC_INIT[0])
    else $error("powered group not running");
  a_bypass_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    st.gst[0] == echo_grp_pkg::GS_DOWN && !frame_tick |=> $stable(ROUT[0]) && $stable(SOUT[0]))
    else $error("bypass output moved between frames");
  a_init_start: assert property (@(posedge CLK) disable iff (!RST_N)
    st.gst[0] == echo_grp_pkg::GS_DOWN && st.ctrl[0][0] |=> CANC_INIT[0] ##0 CANC_ENABLE[0])
    else $error("power rise did not start init");
  a_init_frames: assert property (@(posedge CLK) disable iff (!RST_N)
    st.gst[0] == echo_grp_pkg::GS_INIT && st.init_cnt[0] == 2'h1 && frame_tick && st.ctrl[0][0]
    |=> !CANC_INIT[0] && st.status[2])
    else $error("init did not end after two frames");
  a_mask_a_pass: assert property (@(posedge CLK) disable iff (!RST_N)
    st.status[0] && st.mask[0] && !st.ctrl[0][echo_grp_pkg::BIT_MASK_A] |=> IRQ)
    else $error("unmasked tone A not passed");
  a_down_enable: assert property (@(posedge CLK) disable iff (!RST_N)
    !st.ctrl[0][echo_grp_pkg::BIT_PWR] |=> !CANC_ENABLE[0])
    else $error("cleared power bit left group running");
  a_bypass_delay: assert property (@(posedge CLK) disable iff (!RST_N)
    st.gst[0] == echo_grp_pkg::GS_DOWN && frame_tick |=> ROUT[0] == $past(st.rbp[0][NB-1]))
    else $error("bypass output not two frames old");
endmodule
`default_nettype wire

// File: verif/canc_model.sv
`timescale 1ns/1ps
`default_nettype none
module canc_model (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // From the block and the bench
  input wire logic [2:0] enable,
  input wire logic [2:0] tone_a_req,
  input wire logic [2:0] tone_b_req,
  // Canceller outputs
  output logic [2:0][7:0] rout,
  output logic [2:0][7:0] sout,
  output logic [2:0] tone_a,
  output logic [2:0] tone_b
);
  logic [7:0] cnt;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt <= 8'h00;
      rout <= '0;
      sout <= '0;
      tone_a <= 3'h0;
      tone_b <= 3'h0;
    end else begin
      cnt <= cnt + 8'h01;
      for (int g = 0; g < 3; g++) begin
        // Idle canceller shows a moving pattern, never a held value
        rout[g] <= enable[g] ? (8'h5A ^ 8'(g)) : cnt;
        sout[g] <= enable[g] ? (8'hC3 ^ 8'(g)) : ~cnt;
      end
      tone_a <= tone_a_req;
      tone_b <= tone_b_req;
    end
  end
endmodule
`default_nettype wire

// File: verif/echo_group_main_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module echo_group_main_control_bench;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, fsync;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, v;
  logic [1:0] bresp, rresp, r;
  logic [3:0] strb;
  logic [2:0][7:0] rin, sin, rout, sout, c_rin, c_sin, c_rout, c_sout;
  logic [2:0] c_en, c_alaw, c_init, ta, tb, ta_req, tb_req, up;
  logic [2:0][7:0] qr[$];
  logic [2:0][7:0] qs[$];
  integer miscompares, samples_checked, seed, i, g, k;

  echo_group_main_control uut (.CLK(clk), .RST_N(rst_n), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(strb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .FRAME_SYNC(fsync), .RIN(rin),
    .SIN(sin), .ROUT(rout), .SOUT(sout), .CANC_RIN(c_rin), .CANC_SIN(c_sin), .CANC_ROUT(c_rout),
    .CANC_SOUT(c_sout), .CANC_ENABLE(c_en), .CANC_ALAW(c_alaw), .CANC_INIT(c_init),
    .TONE_A_EVT(ta), .TONE_B_EVT(tb), .IRQ(irq));
  canc_model far (.CLK(clk), .RST_N(rst_n), .enable(c_en), .tone_a_req(ta_req), .tone_b_req(tb_req),
    .rout(c_rout), .sout(c_sout), .tone_a(ta), .tone_b(tb));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] adr(input logic [11:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction
  task end_sim();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [15:0] a, input logic [31:0] dat);
    logic aw, w;
    @(posedge clk);
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w) begin
      @(posedge clk);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge clk);
    r = bresp;
    bready <= 1'b0;
  endtask
  task rd(input logic [15:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // One frame: new samples, sync strobe, then compare against the delay model
  task frame();
    v = $random(seed);
    rin <= v[23:0];
    v = $random(seed);
    sin <= v[23:0];
    fsync <= 1'b1;
    repeat (2) @(posedge clk);
    fsync <= 1'b0;
    repeat (6) @(posedge clk);
    qr.push_back(rin);
    qs.push_back(sin);
    for (int n = 0; n < 3; n++) begin
      chk(c_rin[n], qr[qr.size() - 1][n]);
      chk(c_sin[n], qs[qs.size() - 1][n]);
      if (up[n]) begin
        chk(rout[n], 8'h5A ^ 8'(n));
        chk(sout[n], 8'hC3 ^ 8'(n));
      end else if (qr.size() >= 3) begin
        chk(rout[n], qr[qr.size() - 3][n]);
        chk(sout[n], qs[qs.size() - 3][n]);
      end
    end
  endtask
  task pulse(input integer kk);
    @(posedge clk);
    ta_req <= (kk == 0) ? 3'b001 : 3'b000;
    tb_req <= (kk == 1) ? 3'b001 : 3'b000;
    @(posedge clk);
    ta_req <= 3'b000;
    tb_req <= 3'b000;
  endtask

  // ----------------------------------------
  // Clock, watchdog and sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end
  initial begin
    seed = 32'ha6ca_2423;
    miscompares = 0;
    samples_checked = 0;
    {awvalid, wvalid, bready, arvalid, rready, fsync} = '0;
    {awaddr, araddr, wdata, rin, sin, ta_req, tb_req, up} = '0;
    strb = 4'hF;
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    for (g = 0; g < 3; g++) begin
      rd(adr(12'(echo_grp_pkg::IDX_GRP1 + g)));
      chk(d, 32'h0000_0000);
      chk(r, echo_grp_pkg::RESP_OKAY);
    end
    for (i = 0; i < 6; i++) begin
      g = i % 3;
      v = $random(seed) & 32'h0000_00FE;
      wr(adr(12'(echo_grp_pkg::IDX_GRP1 + g)), v);
      chk(r, echo_grp_pkg::RESP_OKAY);
      rd(adr(12'(echo_grp_pkg::IDX_GRP1 + g)));
      chk(d, v & 32'h0000_001F);
      chk(c_alaw[g], v[1]);
      chk(c_en[g], 1'b0);
    end
    for (g = 0; g < 3; g++) begin
      wr(adr(12'(echo_grp_pkg::IDX_GRP1 + g)), 32'h0000_0000);
    end
    rd(16'h0FFC);
    chk(r, echo_grp_pkg::RESP_DECERR);
    wr(16'h2000, 32'hFFFF_FFFF);
    chk(r, echo_grp_pkg::RESP_DECERR);
    repeat (4) frame();
    wr(adr(echo_grp_pkg::IDX_GRP1), 32'h0000_0001);
    up[0] = 1'b1;
    rd(adr(echo_grp_pkg::IDX_GRP_STATE));
    chk(d, 32'h0000_0003);
    chk(c_init, 3'b001);
    chk(c_en, 3'b001);
    // Host holds off per-channel writes for the two init frames
    repeat (2) frame();
    rd(adr(echo_grp_pkg::IDX_GRP_STATE));
    chk(d, 32'h0000_0001);
    chk(c_init, 3'b000);
    rd(adr(echo_grp_pkg::IDX_IRQ_STATUS));
    chk(d, 32'h0000_0004);
    wr(adr(echo_grp_pkg::IDX_IRQ_STATUS), 32'h0000_01FF);
    // Only byte 0 strobed: bit 8 of the mask stays clear
    strb <= 4'h1;
    wr(adr(echo_grp_pkg::IDX_IRQ_MASK), 32'h0000_01FF);
    strb <= 4'hF;
    rd(adr(echo_grp_pkg::IDX_IRQ_MASK));
    chk(d, 32'h0000_00FF);
    wr(adr(echo_grp_pkg::IDX_IRQ_MASK), 32'h0000_0003);
    for (k = 0; k < 2; k++) begin
      wr(adr(echo_grp_pkg::IDX_GRP1), 32'h0000_0001 | (32'h0000_0008 << k));
      pulse(k);
      repeat (3) @(posedge clk);
      chk(irq, 1'b0);
      rd(adr(echo_grp_pkg::IDX_IRQ_STATUS));
      chk(d, 32'h0000_0001 << k);
      wr(adr(echo_grp_pkg::IDX_GRP1), 32'h0000_0001);
      repeat (2) @(posedge clk);
      chk(irq, 1'b1);
      wr(adr(echo_grp_pkg::IDX_IRQ_STATUS), 32'h0000_0001 << k);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
    end
    frame();
    // Power bit low again drops the running group back to bypass
    wr(adr(echo_grp_pkg::IDX_GRP1), 32'h0000_0000);
    up[0] = 1'b0;
    repeat (2) frame();
    chk(c_en, 3'b000);
    end_sim();
  end
endmodule
`default_nettype wire
